/* File: logic/apgc_map.vh */
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: 200 MHz pclk, 32-bit APB data, one aligned word per register
// Notes: included by the pulse logic only
`ifndef APGC_MAP_VH
`define APGC_MAP_VH
// timing
`define APGC_CLK_HZ 200000000
`define APGC_MS_CYCLES (`APGC_CLK_HZ / 1000)
`define APGC_UM_PHASE 25'd12000000
`define APGC_RAMP_SPEED 24'd15000
`define APGC_RATE_MAX 511
`define APGC_RATE_SPEED 30000
// register offsets
`define APGC_A_CTRL 8'h00
`define APGC_A_PREC 8'h04
`define APGC_A_THREAD_T 8'h08
`define APGC_A_RUNOUT_T 8'h0c
`define APGC_A_SYNC_START 8'h10
`define APGC_A_P2C_DELAY 8'h14
`define APGC_A_ENC_LINES 8'h18
`define APGC_A_SYNC_TARGET 8'h1c
`define APGC_A_CMD 8'h20
`define APGC_A_STATUS 8'h24
`define APGC_A_ENC_COUNT 8'h28
`define APGC_A_ENC_MEAS 8'h2c
`define APGC_A_FEED 8'h30
`define APGC_A_RAPID_OVR 8'h34
`define APGC_A_COMP_DATA 8'h38
`define APGC_A_AXIS_BASE 8'h40
`define APGC_A_AXIS_END 8'ha0
// precision config fields
`define APGC_PREC_MASK 8'hf2
`define APGC_B_PITCH_EN 7
`define APGC_B_PITCH_REP 6
`define APGC_B_NOSE_EN 5
`define APGC_B_CORNER 4
`define APGC_B_BL_SPEED 1
`define APGC_COMP_CORNERS 9'd150
`define APGC_COMP_POINTS 9'd300
// status fields
`define APGC_B_RATE_ALM 5
// limits and reset values
`define APGC_GEAR_MIN 17'd1
`define APGC_GEAR_MAX 17'd99999
`define APGC_GEAR_RATIO 8'd128
`define APGC_LINES_MIN 13'd100
`define APGC_LINES_MAX 13'd5000
`define APGC_RST_LINES 13'd1024
`define APGC_RST_MAX_SPD 16'd5000
`define APGC_RST_MIN_SPD 16'd100
`define APGC_RST_ACCEL 16'd100
`define APGC_RST_OVR 8'd100
// command types
`define APGC_C_RAPID 3'd0
`define APGC_C_CUT 3'd1
`define APGC_C_THREAD 3'd2
`define APGC_C_RUNOUT 3'd3
`define APGC_C_FPR 3'd4
`define APGC_C_OTHER 3'd5
`define APGC_C_NOSE_L 3'd6
`define APGC_C_NOSE_R 3'd7
`endif

/* File: logic/apgc_axis_pulse.v */
// Purpose: three-axis command pulse logic with gear, ramps, sync, backlash
// Assumes: single pclk domain, APB slave, encoder pins asynchronous
// Notes: one motion command at a time, command writes refused while busy
// Notes on behaviour
// - thread ramp, zero to 15 m/min in time
// - run-out uses its own ramp time
// - zero start setting waits for encoder angle
// - nonzero start setting skips angle wait
// - encoder counts four times lines, wrapping
// - out-of-range angle target waits forever
// - rapid then cutting inserts programmed delay
// - intervening command suppresses that delay
// - per-axis gear numerator, denominator 1..99999
// - alarm when gear ratio outside 1/128..128
// - Z/Y emit num/den pulses per micron
// - X radius doubles pulses, diameter does not
// - cap 511 pulses per ms, alarm
// - lines 100..5000, diagnosis mismatch flag
// - backlash motion added on direction reversal
// - pitch compensation follows its enable bit
// - compensation entries limited 150 or 300
// - representation change clears compensation data
// - nose radius commands need enable bit
// - corner mode bit picks line or arc, only while nose enable bit set
// - backlash speed bit picks min or max
// - rapid speed is max times override
// - speed below minimum raised to minimum
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "apgc_map.vh"
module apgc_axis_pulse #(
    parameter MS_CYCLES = `APGC_MS_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire enc_a,
    input wire enc_b,
    input wire enc_index,
    output reg z_step,
    output reg z_dir,
    output reg x_step,
    output reg x_dir,
    output reg y_step,
    output reg y_dir,
    output reg pitch_comp_active,
    output reg [1:0] nose_comp_side,
    output reg corner_arc
);
    localparam S_IDLE = 3'd0;
    localparam S_SYNC = 3'd1;
    localparam S_DELAY = 3'd2;
    localparam S_BACK = 3'd3;
    localparam S_MOVE = 3'd4;

    // ratio outside 1/128..128
    function gear_bad;
        input [16:0] num;
        input [16:0] den;
        begin
            gear_bad = ({8'h00, num} * `APGC_GEAR_RATIO < {8'h00, den}) ||
                       ({8'h00, num} > {8'h00, den} * `APGC_GEAR_RATIO);
        end
    endfunction

    // max speed times ratio above the pulse-rate speed limit
    function rate_bad;
        input [15:0] spd;
        input [16:0] num;
        input [16:0] den;
        input dbl;
        reg [34:0] lhs;
        begin
            lhs = {19'h00000, spd} * {18'h00000, num};
            if (dbl)
                lhs = {lhs[33:0], 1'b0};
            rate_bad = lhs > {18'h00000, den} * `APGC_RATE_SPEED;
        end
    endfunction

    reg [2:0] ctrl_q;
    reg [7:0] prec_q;
    reg [15:0] thread_accel_time;
    reg [15:0] runout_accel_time;
    reg [14:0] spindle_sync_start_angle;
    reg [14:0] sync_target_q;
    reg [15:0] position_to_cut_delay;
    reg [12:0] spindle_encoder_line_count;
    reg [15:0] feed_q;
    reg [7:0] ovr_q;
    reg [8:0] comp_cnt_q;
    reg [16:0] gear_num [0:2];
    reg [16:0] gear_den [0:2];
    reg [15:0] backlash_value [0:2];
    reg [15:0] max_traverse_speed [0:2];
    reg [15:0] min_initial_speed [0:2];
    reg rate_alm_q;
    reg [2:0] st_q;
    reg [2:0] type_q;
    reg [1:0] axis_q;
    reg dir_q;
    reg [15:0] dist_q;
    reg [15:0] remain_q;
    reg [19:0] acc_q;
    reg [24:0] phase_q;
    reg [15:0] speed_q;
    reg [23:0] ramp_q;
    reg [15:0] dly_q;
    reg [2:0] last_dir_q;
    reg prev_rapid_q;
    reg [17:0] msdiv_q;
    reg [8:0] ms_pulses_q;
    reg [2:0] a_s, b_s, z_s;
    reg a_st_q, b_st_q, z_st_q;
    reg [14:0] enc_cnt_q;
    reg [14:0] rev_cnt_q;
    reg [12:0] meas_q;
    reg meas_ok_q;
    integer i, j;

    wire acc_ph = psel & penable;
    wire wr = acc_ph & pwrite;
    wire axis_hit = paddr >= `APGC_A_AXIS_BASE && paddr < `APGC_A_AXIS_END;
    wire [7:0] axis_off = paddr - `APGC_A_AXIS_BASE;
    wire [1:0] wax = axis_off[6:5];
    wire [2:0] wfld = axis_off[4:2];
    wire busy = st_q != S_IDLE;
    wire radius_mode = ctrl_q[0];
    wire diag_mode = ctrl_q[1];
    wire spindle_on = ctrl_q[2];
    wire ms_tick = msdiv_q == MS_CYCLES - 1;
    wire [16:0] num = gear_num[axis_q];
    wire [16:0] den = gear_den[axis_q];
    wire gear_ok_d = (pwdata[16:0] >= `APGC_GEAR_MIN) &&
                     (pwdata[16:0] <= `APGC_GEAR_MAX) && pwdata[31:17] == 0;
    wire [12:0] lines_w = pwdata[12:0];
    wire [15:0] quad_top = {spindle_encoder_line_count, 2'b00} - 16'd1;
    wire [23:0] rapid_spd = ({8'h00, max_traverse_speed[axis_q]} *
        {16'h0000, ovr_q}) / 24'd100;
    reg hit;
    reg [31:0] rd_d;
    reg [2:0] gear_alm;
    reg [2:0] rate_cfg_alm;
    reg [15:0] base_spd;
    reg [15:0] spd;
    reg [19:0] inc;

    assign pready = acc_ph;
    assign pslverr = acc_ph & (~hit | (pwrite & busy & paddr == `APGC_A_CMD));

    // static gear and rate checks per axis
    always @* begin
        for (j = 0; j < 3; j = j + 1) begin
            gear_alm[j] = gear_bad(gear_num[j], gear_den[j]);
            rate_cfg_alm[j] = rate_bad(max_traverse_speed[j], gear_num[j],
                gear_den[j], radius_mode && j == 1);
        end
    end

    // register read decode
    always @* begin
        hit = 1'b1;
        rd_d = 32'h00000000;
        if (axis_hit) begin
            hit = wfld < 3'd5 && wax < 2'd3;
            case (wfld)
                3'd0: rd_d = {15'h0000, gear_num[wax]};
                3'd1: rd_d = {15'h0000, gear_den[wax]};
                3'd2: rd_d = {16'h0000, backlash_value[wax]};
                3'd3: rd_d = {16'h0000, max_traverse_speed[wax]};
                3'd4: rd_d = {16'h0000, min_initial_speed[wax]};
                default: rd_d = 32'h00000000;
            endcase
        end else begin
            case (paddr)
                `APGC_A_CTRL: rd_d = {29'h0, ctrl_q};
                `APGC_A_PREC: rd_d = {24'h0, prec_q};
                `APGC_A_THREAD_T: rd_d = {16'h0, thread_accel_time};
                `APGC_A_RUNOUT_T: rd_d = {16'h0, runout_accel_time};
                `APGC_A_SYNC_START: rd_d = {17'h0, spindle_sync_start_angle};
                `APGC_A_P2C_DELAY: rd_d = {16'h0, position_to_cut_delay};
                `APGC_A_ENC_LINES: rd_d = {19'h0, spindle_encoder_line_count};
                `APGC_A_SYNC_TARGET: rd_d = {17'h0, sync_target_q};
                `APGC_A_CMD: rd_d = 32'h00000000;
                `APGC_A_STATUS: rd_d = {19'h0, rate_cfg_alm, pitch_comp_active,
                    nose_comp_side,
                    diag_mode & spindle_on & meas_ok_q &
                    (meas_q != spindle_encoder_line_count),
                    rate_alm_q, gear_alm, st_q == S_SYNC, busy};
                `APGC_A_ENC_COUNT: rd_d = {17'h0, enc_cnt_q};
                `APGC_A_ENC_MEAS: rd_d = {19'h0, meas_q};
                `APGC_A_FEED: rd_d = {16'h0, feed_q};
                `APGC_A_RAPID_OVR: rd_d = {24'h0, ovr_q};
                `APGC_A_COMP_DATA: rd_d = {23'h0, comp_cnt_q};
                default: hit = 1'b0;
            endcase
        end
    end

    // read data latched in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel & ~penable & ~pwrite)
            prdata <= rd_d;
    end

    // configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 3'h0;
            prec_q <= 8'h00;
            thread_accel_time <= `APGC_RST_ACCEL;
            runout_accel_time <= `APGC_RST_ACCEL;
            spindle_sync_start_angle <= 15'h0000;
            sync_target_q <= 15'h0000;
            position_to_cut_delay <= 16'h0000;
            spindle_encoder_line_count <= `APGC_RST_LINES;
            feed_q <= 16'h0000;
            ovr_q <= `APGC_RST_OVR;
            comp_cnt_q <= 9'h000;
            for (i = 0; i < 3; i = i + 1) begin
                gear_num[i] <= 17'h00001;
                gear_den[i] <= 17'h00001;
                backlash_value[i] <= 16'h0000;
                max_traverse_speed[i] <= `APGC_RST_MAX_SPD;
                min_initial_speed[i] <= `APGC_RST_MIN_SPD;
            end
        end else if (wr && axis_hit && wax < 2'd3) begin
            case (wfld)
                3'd0: if (gear_ok_d) gear_num[wax] <= pwdata[16:0];
                3'd1: if (gear_ok_d) gear_den[wax] <= pwdata[16:0];
                3'd2: backlash_value[wax] <= pwdata[15:0];
                3'd3: max_traverse_speed[wax] <= pwdata[15:0];
                3'd4: min_initial_speed[wax] <= pwdata[15:0];
                default: ;
            endcase
        end else if (wr) begin
            case (paddr)
                `APGC_A_CTRL: ctrl_q <= pwdata[2:0];
                `APGC_A_PREC: begin
                    prec_q <= pwdata[7:0] & `APGC_PREC_MASK;
                    if (pwdata[`APGC_B_PITCH_REP] != prec_q[`APGC_B_PITCH_REP])
                        comp_cnt_q <= 9'h000;
                end
                `APGC_A_THREAD_T: thread_accel_time <= pwdata[15:0];
                `APGC_A_RUNOUT_T: runout_accel_time <= pwdata[15:0];
                `APGC_A_SYNC_START: spindle_sync_start_angle <= pwdata[14:0];
                `APGC_A_P2C_DELAY: position_to_cut_delay <= pwdata[15:0];
                `APGC_A_ENC_LINES:
                    if (pwdata[31:13] == 0 && lines_w >= `APGC_LINES_MIN &&
                        lines_w <= `APGC_LINES_MAX)
                        spindle_encoder_line_count <= lines_w;
                `APGC_A_SYNC_TARGET: sync_target_q <= pwdata[14:0];
                `APGC_A_FEED: feed_q <= pwdata[15:0];
                `APGC_A_RAPID_OVR: ovr_q <= pwdata[7:0];
                `APGC_A_COMP_DATA:
                    if (comp_cnt_q < (prec_q[`APGC_B_PITCH_REP] ?
                        `APGC_COMP_POINTS : `APGC_COMP_CORNERS))
                        comp_cnt_q <= comp_cnt_q + 9'd1;
                default: ;
            endcase
        end
    end

    // encoder pins through three flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_s <= 3'h0;
            b_s <= 3'h0;
            z_s <= 3'h0;
        end else begin
            a_s <= {a_s[1:0], enc_a};
            b_s <= {b_s[1:0], enc_b};
            z_s <= {z_s[1:0], enc_index};
        end
    end

    wire a_n = (a_s[1] == a_s[2]) ? a_s[1] : a_st_q;
    wire b_n = (b_s[1] == b_s[2]) ? b_s[1] : b_st_q;
    wire z_n = (z_s[1] == z_s[2]) ? z_s[1] : z_st_q;
    wire q_step = (a_n ^ a_st_q) ^ (b_n ^ b_st_q);
    wire q_up = a_st_q ^ b_n;

    // quadrature count, wrap and line measurement
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_st_q <= 1'b0;
            b_st_q <= 1'b0;
            z_st_q <= 1'b0;
            enc_cnt_q <= 15'h0000;
            rev_cnt_q <= 15'h0000;
            meas_q <= 13'h0000;
            meas_ok_q <= 1'b0;
        end else begin
            a_st_q <= a_n;
            b_st_q <= b_n;
            z_st_q <= z_n;
            if (q_step) begin
                if (q_up)
                    enc_cnt_q <= ({1'b0, enc_cnt_q} >= quad_top) ? 15'h0000 :
                        enc_cnt_q + 15'd1;
                else
                    enc_cnt_q <= (enc_cnt_q == 0) ? quad_top[14:0] :
                        enc_cnt_q - 15'd1;
            end
            if (z_n & ~z_st_q) begin
                meas_q <= rev_cnt_q[14:2];
                meas_ok_q <= 1'b1;
                rev_cnt_q <= 15'h0000;
            end else if (q_step && rev_cnt_q != 15'h7fff) begin
                rev_cnt_q <= rev_cnt_q + 15'd1;
            end
        end
    end

    // speed selection and pulses added per micron
    always @* begin
        if (st_q == S_BACK)
            base_spd = prec_q[`APGC_B_BL_SPEED] ? max_traverse_speed[axis_q] :
                min_initial_speed[axis_q];
        else if (type_q == `APGC_C_RAPID)
            base_spd = rapid_spd[15:0];
        else if (type_q == `APGC_C_CUT)
            base_spd = feed_q;
        else
            base_spd = speed_q;
        spd = (base_spd < min_initial_speed[axis_q]) ?
            min_initial_speed[axis_q] : base_spd;
        inc = (axis_q == 2'd1 && radius_mode) ? {2'b00, num, 1'b0} :
            {3'b000, num};
    end

    wire moving = st_q == S_BACK || st_q == S_MOVE;
    wire um_tick = moving && phase_q >= `APGC_UM_PHASE;
    wire take = um_tick && remain_q != 0;
    wire due = acc_q >= {3'b000, den};
    wire capped = ms_pulses_q >= `APGC_RATE_MAX;
    wire emit = moving && due && !capped;
    wire [15:0] ramp_t = (type_q == `APGC_C_RUNOUT) ? runout_accel_time :
        thread_accel_time;
    wire ramping = st_q == S_MOVE && (type_q == `APGC_C_THREAD ||
        type_q == `APGC_C_RUNOUT);
    wire [23:0] ramp_add = ms_tick ? ramp_q + `APGC_RAMP_SPEED : ramp_q;
    wire cmd_wr = wr && paddr == `APGC_A_CMD && !busy;
    wire [2:0] cmd_type = pwdata[18:16];
    wire [1:0] cmd_axis = (pwdata[21:20] == 2'd3) ? 2'd0 : pwdata[21:20];
    wire cutting = cmd_type == `APGC_C_CUT || cmd_type == `APGC_C_THREAD;
    wire reverse = last_dir_q[cmd_axis] != pwdata[24] &&
        backlash_value[cmd_axis] != 0;

    // millisecond base and per-window pulse count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msdiv_q <= 18'h00000;
            ms_pulses_q <= 9'h000;
            rate_alm_q <= 1'b0;
        end else begin
            msdiv_q <= ms_tick ? 18'h00000 : msdiv_q + 18'd1;
            if (ms_tick)
                ms_pulses_q <= 9'h000;
            else if (emit)
                ms_pulses_q <= ms_pulses_q + 9'd1;
            if (moving && due && capped)
                rate_alm_q <= 1'b1;
            else if (wr && paddr == `APGC_A_STATUS &&
                pwdata[`APGC_B_RATE_ALM])
                rate_alm_q <= 1'b0;
        end
    end

    // motion sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            type_q <= 3'h0;
            axis_q <= 2'h0;
            dir_q <= 1'b0;
            dist_q <= 16'h0000;
            remain_q <= 16'h0000;
            acc_q <= 20'h00000;
            phase_q <= 25'h0000000;
            speed_q <= 16'h0000;
            ramp_q <= 24'h000000;
            dly_q <= 16'h0000;
            last_dir_q <= 3'h0;
            prev_rapid_q <= 1'b0;
            nose_comp_side <= 2'h0;
        end else begin
            if (!prec_q[`APGC_B_NOSE_EN])
                nose_comp_side <= 2'h0;
            if (moving) begin
                phase_q <= (um_tick ? phase_q - `APGC_UM_PHASE : phase_q) +
                    {9'h000, spd};
                acc_q <= acc_q + (take ? inc : 20'h00000) -
                    (emit ? {3'b000, den} : 20'h00000);
                if (take)
                    remain_q <= remain_q - 16'd1;
            end
            if (ramping) begin
                if (ramp_t == 0) begin
                    speed_q <= feed_q;
                end else if (ramp_add >= {8'h00, ramp_t}) begin
                    ramp_q <= ramp_add - {8'h00, ramp_t};
                    if (speed_q < feed_q)
                        speed_q <= speed_q + 16'd1;
                end else begin
                    ramp_q <= ramp_add;
                end
            end
            case (st_q)
                S_IDLE: if (cmd_wr) begin
                    type_q <= cmd_type;
                    axis_q <= cmd_axis;
                    dir_q <= pwdata[24];
                    dist_q <= pwdata[15:0];
                    speed_q <= 16'h0000;
                    ramp_q <= 24'h000000;
                    acc_q <= 20'h00000;
                    phase_q <= 25'h0000000;
                    prev_rapid_q <= cmd_type == `APGC_C_RAPID;
                    dly_q <= position_to_cut_delay;
                    if (cmd_type == `APGC_C_NOSE_L ||
                        cmd_type == `APGC_C_NOSE_R) begin
                        if (prec_q[`APGC_B_NOSE_EN])
                            nose_comp_side <= cmd_type[0] ? 2'd2 : 2'd1;
                    end else if (cmd_type == `APGC_C_FPR) begin
                        if (spindle_sync_start_angle == 0)
                            st_q <= S_SYNC;
                    end else if (cmd_type != `APGC_C_OTHER) begin
                        if (cutting && prev_rapid_q &&
                            position_to_cut_delay != 0)
                            st_q <= S_DELAY;
                        else if (reverse) begin
                            remain_q <= backlash_value[cmd_axis];
                            st_q <= S_BACK;
                        end else begin
                            remain_q <= pwdata[15:0];
                            st_q <= S_MOVE;
                        end
                    end
                end
                S_SYNC: if (enc_cnt_q == sync_target_q)
                    st_q <= S_IDLE;
                S_DELAY: if (dly_q == 0) begin
                    if (last_dir_q[axis_q] != dir_q &&
                        backlash_value[axis_q] != 0) begin
                        remain_q <= backlash_value[axis_q];
                        st_q <= S_BACK;
                    end else begin
                        remain_q <= dist_q;
                        st_q <= S_MOVE;
                    end
                end else if (ms_tick) begin
                    dly_q <= dly_q - 16'd1;
                end
                S_BACK: if (remain_q == 0 && !due) begin
                    last_dir_q[axis_q] <= dir_q;
                    remain_q <= dist_q;
                    st_q <= S_MOVE;
                end
                S_MOVE: if (remain_q == 0 && !due) begin
                    last_dir_q[axis_q] <= dir_q;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // registered step and direction pins, compensation outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_step <= 1'b0;
            x_step <= 1'b0;
            y_step <= 1'b0;
            z_dir <= 1'b0;
            x_dir <= 1'b0;
            y_dir <= 1'b0;
            pitch_comp_active <= 1'b0;
            corner_arc <= 1'b0;
        end else begin
            z_step <= emit && axis_q == 2'd0;
            x_step <= emit && axis_q == 2'd1;
            y_step <= emit && axis_q == 2'd2;
            if (moving && axis_q == 2'd0)
                z_dir <= dir_q;
            if (moving && axis_q == 2'd1)
                x_dir <= dir_q;
            if (moving && axis_q == 2'd2)
                y_dir <= dir_q;
            pitch_comp_active <= prec_q[`APGC_B_PITCH_EN];
            corner_arc <= prec_q[`APGC_B_CORNER] &&
                prec_q[`APGC_B_NOSE_EN];
        end
    end
endmodule // apgc_axis_pulse

/* File: verif/apgc_assertions.sv */
// Purpose: port checks for the axis pulse block
// Assumes: one pclk domain, async active-low reset
// Notes: rate window counted from reset release
`timescale 1ns/1ps
module apgc_assertions #(parameter MS_CYCLES = 200) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire z_step,
    input wire x_step,
    input wire z_dir,
    input wire pitch_comp_active,
    input wire corner_arc
);
    reg [31:0] cyc_q;
    reg [9:0] n_q;
    wire acc = psel && penable;
    wire wp = acc && pwrite && paddr == 8'h04;
    wire bad = acc && paddr == 8'ha0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // z steps seen in the current ms window
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 32'h0;
            n_q <= 10'h0;
        end else if (cyc_q == MS_CYCLES - 1) begin
            cyc_q <= 32'h0;
            n_q <= {9'h0, z_step};
        end else begin
            cyc_q <= cyc_q + 32'h1;
            n_q <= n_q + {9'h0, z_step};
        end
    end
    property p_ready; pready == acc; endproperty
    a_ready: assert property (p_ready) else $error("pready wrong");
    property p_err; bad |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_rd0; bad && !pwrite |-> prdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped data");
    property p_pitch;
        wp |=> ##1 pitch_comp_active == $past(pwdata[7], 2);
    endproperty
    a_pitch: assert property (p_pitch) else $error("pitch");
    property p_corner;
        wp |=> ##1 corner_arc == ($past(pwdata[4], 2) && $past(pwdata[5], 2));
    endproperty
    a_corner: assert property (p_corner) else $error("corner");
    property p_cap; n_q <= 10'd511; endproperty
    a_cap: assert property (p_cap) else $error("rate cap");
    property p_axis; z_step |-> !x_step; endproperty
    a_axis: assert property (p_axis) else $error("two axes");
    property p_dir; z_step |-> $stable(z_dir); endproperty
    a_dir: assert property (p_dir) else $error("dir moved");
    c_prec: cover property (wp);
    c_step: cover property (z_step ##1 !z_step);
    c_bad: cover property (bad);
endmodule // apgc_assertions
bind apgc_axis_pulse apgc_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .z_step, .x_step, .z_dir, .pitch_comp_active,
    .corner_arc);

/* File: verif/apgc_drive_model.sv */
// Purpose: axis drives counting steps, spindle encoder phases
// Assumes: steps are one-cycle pulses on pclk
// Notes: encoder stands still unless turn is called
`timescale 1ns/1ps
module apgc_drive_model (
    input wire pclk,
    input wire z_step,
    input wire x_step,
    output wire enc_a,
    output wire enc_b,
    output wire enc_index,
    output reg [15:0] z_n,
    output reg [15:0] x_n
);
    reg [1:0] ph = 2'h0;
    initial z_n = 16'h0;
    initial x_n = 16'h0;
    // gray-coded phases from the shaft position
    assign enc_a = ph[1];
    assign enc_b = ph[1] ^ ph[0];
    assign enc_index = 1'b0;
    // drives count every step pulse
    always @(posedge pclk) begin
        z_n <= z_n + {15'h0, z_step};
        x_n <= x_n + {15'h0, x_step};
    end
    // one forward edge every 8 cycles
    task turn(input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            ph <= ph + 2'h1;
            repeat (8) @(posedge pclk);
        end
    endtask
endmodule // apgc_drive_model

/* File: verif/apgc_axis_pulse_tb.sv */
// Purpose: register, motion and encoder tests for the axis pulse block
// Assumes: APB master, MS_CYCLES set to 200
// Notes: step counts come from the drive model
`timescale 1ns/1ps
module apgc_axis_pulse_tb;
    reg pclk, presetn, psel, penable, pwrite, err;
    reg [7:0] paddr;
    reg [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, enc_a, enc_b, enc_index, z_step, z_dir, x_step;
    wire x_dir, y_step, y_dir, pitch_comp_active, corner_arc;
    wire [1:0] nose_comp_side;
    wire [15:0] z_n, x_n;
    integer n_mismatch = 0, compares = 0, i;
    apgc_axis_pulse #(.MS_CYCLES(200)) u_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .enc_a, .enc_b, .enc_index, .z_step, .z_dir, .x_step, .x_dir,
        .y_step, .y_dir, .pitch_comp_active, .nose_comp_side, .corner_arc);
    apgc_drive_model u_drv (.pclk, .z_step, .x_step, .enc_a, .enc_b,
        .enc_index, .z_n, .x_n);
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task xfer(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // wait until busy clears, then compare step counts
    task mv(input [31:0] c, input [15:0] ez, input [15:0] ex);
        reg [15:0] z0, x0;
        begin
            z0 = z_n;
            x0 = x_n;
            xfer(1, 8'h20, c);
            do xfer(0, 8'h24, 0); while (q[0] !== 1'b0);
            chk(z_n - z0, ez);
            chk(x_n - x0, ex);
        end
    endtask
    task results;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1, 8'h40, 32'd0);
        xfer(0, 8'h40, 0);
        chk(q, 32'h1);
        xfer(1, 8'h40, 32'd99999);
        xfer(0, 8'h24, 0);
        chk(q[4:2], 3'b001);
        xfer(1, 8'h40, 32'd128);
        xfer(0, 8'h24, 0);
        chk(q[4:2], 3'b000);
        xfer(0, 8'ha0, 0);
        chk(err, 1'b1);
        xfer(1, 8'h04, 32'hf2);
        repeat (2) @(posedge pclk);
        chk({pitch_comp_active, corner_arc}, 2'b11);
        for (i = 0; i < 301; i = i + 1) xfer(1, 8'h38, i);
        xfer(0, 8'h38, 0);
        chk(q, 32'd300);
        xfer(1, 8'h04, 32'hb2);
        xfer(0, 8'h38, 0);
        chk(q, 32'd0);
        $display("end regs");
        xfer(1, 8'h40, 32'd2);
        xfer(1, 8'h48, 32'd3);
        xfer(1, 8'h4c, 32'd15000);
        xfer(1, 8'h6c, 32'd15000);
        xfer(1, 8'h00, 32'h1);
        mv(32'h0100000a, 16'd26, 16'd0);
        mv(32'h00100008, 16'd0, 16'd16);
        xfer(1, 8'h20, 32'h00060000);
        xfer(0, 8'h24, 0);
        chk({q[8:7], nose_comp_side}, 4'b0101);
        $display("end motion");
        xfer(1, 8'h18, 32'd100);
        u_drv.turn(405);
        xfer(0, 8'h28, 0);
        chk(q, 32'd5);
        xfer(1, 8'h1c, 32'd3);
        xfer(1, 8'h20, 32'h00040000);
        xfer(0, 8'h24, 0);
        chk(q[1], 1'b1);
        u_drv.turn(398);
        mv(32'h01000000, 16'd0, 16'd0);
        xfer(1, 8'h10, 32'd1);
        xfer(1, 8'h20, 32'h00040000);
        xfer(0, 8'h24, 0);
        chk(q[1:0], 2'b00);
        $display("end encoder");
        results;
    end
    // watchdog against a hang
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        results;
    end
endmodule // apgc_axis_pulse_tb
